/* File: verilog/seac_pkg.sv */
// shared constants for the serial rom controller
package seac_pkg;
	// register byte offsets on the apb side
	localparam logic [11:0] ADDR_CSR = 12'h070; // control and status word
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h100; // sticky event bits, write one to clear
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h104; // event enables
	localparam logic [11:0] ADDR_SHADOW = 12'h180; // autoloaded words, one per register slot
	localparam int SHADOW_TAG_LSB = 6; // bits from this one up pick the shadow window

	// control word field positions
	localparam int B_INIT = 0;
	localparam int B_CMD = 1;
	localparam int B_ERR = 2;
	localparam int B_DONE = 3;
	localparam int F_CLK_LSB = 4;
	localparam int B_LDIS = 6;
	localparam int B_FAST = 7;
	localparam int B_BUSY = 8;
	localparam int F_ADDR_LSB = 9;
	localparam int F_DATA_LSB = 16;
	localparam int ADDR_W = 7; // eeprom word address width
	localparam int DATA_W = 16; // eeprom word width
	localparam logic FAST_RST = 1'b1; // fast autoload out of reset

	// interrupt status bits
	localparam int IRQ_ACC = 0; // software access finished
	localparam int IRQ_NACK = 1; // missing acknowledge seen
	localparam int IRQ_LOAD = 2; // autoload finished
	localparam int IRQ_W = 3;

	// serial clock divide ratios, in core clocks per serial bit
	localparam int DIV_SEL0 = 4096;
	localparam int DIV_SEL1 = 2048;
	localparam int DIV_SEL2 = 1024;
	localparam int DIV_SEL3 = 128;
	localparam int QUARTERS = 4; // each bit is four phases
	localparam int FAST_SHIFT = 3; // fast autoload runs eight times quicker
	localparam int QCNT_W = 11; // holds the longest quarter count
	localparam logic [QCNT_W-1:0] Q_SEL0 = QCNT_W'(DIV_SEL0 / QUARTERS);
	localparam logic [QCNT_W-1:0] Q_SEL1 = QCNT_W'(DIV_SEL1 / QUARTERS);
	localparam logic [QCNT_W-1:0] Q_SEL2 = QCNT_W'(DIV_SEL2 / QUARTERS);
	localparam logic [QCNT_W-1:0] Q_SEL3 = QCNT_W'(DIV_SEL3 / QUARTERS);

	// serial sequencing
	localparam logic [1:0] Q_SAMPLE = 2'd2; // phase in which the data line is sampled
	localparam logic [1:0] Q_LAST = 2'd3;
	localparam logic [3:0] LAST_BIT = 4'd8; // bit slot 8 is the acknowledge
	localparam logic [2:0] BYTE_MSB = 3'd7;
	localparam logic [2:0] STEP_FIRST = 3'd0;
	localparam logic [2:0] STEP_CTRL = 3'd1;
	localparam logic [2:0] STEP_WADDR = 3'd2;
	localparam logic [2:0] STEP_RSTART = 3'd3; // repeated start on reads
	localparam logic [2:0] STEP_DHI = 3'd3; // high data byte on writes
	localparam logic [2:0] STEP_CTRL_RD = 3'd4;
	localparam logic [2:0] STEP_RX_HI = 3'd5;
	localparam logic [2:0] STEP_STOP_WR = 3'd5;
	localparam logic [2:0] STEP_STOP_RD = 3'd7;

	// autoload image
	localparam int LOAD_WORDS = 16;
	localparam int LOAD_AW = 4;

	typedef enum logic [1:0] {OP_START, OP_TX, OP_RX, OP_STOP} seac_op_t;
	typedef enum logic {S_IDLE, S_RUN} seac_state_t;
endpackage

/* File: verilog/seac_clkdiv.sv */
`timescale 1ns/1ns
// phase tick generator for the serial clock
module seac_clkdiv (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic run,
	input wire logic [1:0] sel,
	input wire logic fast,
	output logic tick
);
	import seac_pkg::*;

	logic [QCNT_W-1:0] cnt; // down counter inside one quarter
	logic [QCNT_W-1:0] base; // quarter length from the select code
	logic [QCNT_W-1:0] quarter; // quarter length after the fast shift
	logic [QCNT_W-1:0] reload;

	// ratio lookup
	assign base = (sel == 2'b00) ? Q_SEL0 : (sel == 2'b01) ? Q_SEL1 : (sel == 2'b10) ? Q_SEL2 : Q_SEL3;
	// fast mode divides every quarter by eight
	assign quarter = fast ? (base >> FAST_SHIFT) : base;
	assign reload = quarter - QCNT_W'(1);
	// frozen with the clock enable so phases never slip
	assign tick = ce & run & (cnt == '0);

	// counter reloads while idle so the first quarter is full length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (ce) begin
			if (!run || cnt == '0) begin
				cnt <= reload;
			end else begin
				cnt <= cnt - QCNT_W'(1);
			end
		end
	end

	property p_fast_gap;
		@(posedge pclk) disable iff (!presetn || !ce)
		(tick && fast && sel == 2'b11) |=> (!tick)[*3] ##1 (tick || !run);
	endproperty
	a_fast_gap: assert property (p_fast_gap) else $error("fast quarter is not four clocks");

	property p_slow_gap;
		@(posedge pclk) disable iff (!presetn || !ce)
		(tick && !fast && sel == 2'b11) |=> (!tick)[*8];
	endproperty
	a_slow_gap: assert property (p_slow_gap) else $error("normal quarter too short");
endmodule // seac_clkdiv

/* File: verilog/seac_shadow_mem.sv */
`timescale 1ns/1ns
// holds the autoloaded configuration words
module seac_shadow_mem (
	input wire logic pclk,
	input wire logic ce,
	input wire logic we,
	input wire logic [seac_pkg::LOAD_AW-1:0] waddr,
	input wire logic [seac_pkg::DATA_W-1:0] wdata,
	input wire logic [seac_pkg::LOAD_AW-1:0] raddr,
	output logic [seac_pkg::DATA_W-1:0] rdata
);
	import seac_pkg::*;

	logic [DATA_W-1:0] mem [LOAD_WORDS]; // no reset, contents valid only after a good load

	// one write port from the loader, one registered read port for the bus
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end
endmodule // seac_shadow_mem

/* File: verilog/seac_ctrl.sv */
`timescale 1ns/1ns
// What this block does
// - initiate rising starts cycle, command picks direction
// - initiate bit self-clears when cycle finishes
// - error flag set on missing acknowledge
// - completion flag shows successful autoload
// - serial clock divided by selected ratio
// - autoload runs only when control bit six zero
// - fast bit speeds autoload eightfold, reset one
// - busy bit eight high during autoload
// - word address field addresses software cycle
// - data field supplies word for writes
module seac_ctrl #(
	parameter logic [6:0] DEV_SEL = 7'h50 // bus select code of the rom, arbitrary default
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic rom_scl,
	input wire logic rom_sda_in,
	output logic rom_sda_out,
	output logic rom_sda_oe_n
);
	import seac_pkg::*;

	seac_state_t state; // serial engine state
	logic [2:0] step; // position in the frame
	logic [3:0] bitn; // bit slot within a byte, 8 is acknowledge
	logic [1:0] q; // quarter phase of the current bit
	logic cur_read; // direction of the frame in flight
	logic [ADDR_W-1:0] cur_addr; // word address latched at start
	logic [DATA_W-1:0] cur_wdata; // write word latched at start
	logic [DATA_W-1:0] rx_word; // shift register for read data
	logic nack_cur; // this frame lost an acknowledge
	logic autoload_act; // autoload in progress
	logic load_pending; // autoload still owed since reset
	logic [LOAD_AW-1:0] load_idx; // word being loaded
	// control word fields
	logic init_bit;
	logic cmd_bit;
	logic err_flag;
	logic load_done;
	logic [1:0] clk_sel;
	logic load_dis;
	logic fast_load;
	logic [ADDR_W-1:0] word_addr;
	logic [DATA_W-1:0] data_field;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic mem_wait; // shadow reads take one extra cycle
	// data line synchroniser
	logic sda_s1;
	logic sda_s2;
	logic sda_s3;
	logic sda_filt;

	// bus decode
	wire hit_csr = (paddr == ADDR_CSR);
	wire hit_stat = (paddr == ADDR_IRQ_STAT);
	wire hit_mask = (paddr == ADDR_IRQ_MASK);
	wire hit_mem = (paddr[11:SHADOW_TAG_LSB] == ADDR_SHADOW[11:SHADOW_TAG_LSB]);
	wire hit_any = hit_csr | hit_stat | hit_mask | hit_mem;
	wire access = psel & penable & pready;
	wire wr_en = access & pwrite;
	wire wr_csr = wr_en & hit_csr;
	wire [LOAD_AW-1:0] mem_raddr = paddr[LOAD_AW+1:2];
	wire [DATA_W-1:0] mem_rdata;

	// serial engine decode
	wire tick;
	wire running = (state == S_RUN);
	wire [2:0] stop_step = cur_read ? STEP_STOP_RD : STEP_STOP_WR;
	seac_op_t cur_op;
	assign cur_op = (step == STEP_FIRST || (cur_read && step == STEP_RSTART)) ? OP_START :
		(step == stop_step) ? OP_STOP :
		(cur_read && step >= STEP_RX_HI) ? OP_RX : OP_TX;
	// byte on the wire for each transmit step
	wire [7:0] tx_byte = (step == STEP_CTRL) ? {DEV_SEL, 1'b0} :
		(step == STEP_WADDR) ? {1'b0, cur_addr} :
		cur_read ? {DEV_SEL, 1'b1} :
		(step == STEP_DHI) ? cur_wdata[15:8] : cur_wdata[7:0];
	wire tx_bit = tx_byte[BYTE_MSB - bitn[2:0]];
	wire ack_slot = (bitn == LAST_BIT);
	// acknowledge the high read byte, decline the low one to end the read
	wire rx_ack = (step != STEP_RX_HI);
	wire sda_want = (cur_op == OP_START) ? ~q[1] :
		(cur_op == OP_STOP) ? q[1] :
		(cur_op == OP_TX) ? (ack_slot | tx_bit) : (~ack_slot | rx_ack);
	wire scl_want = (cur_op == OP_STOP) ? (q != 2'd0) : (q == 2'd1 || q == 2'd2);
	wire q_end = tick & (q == Q_LAST);
	wire sample = tick & (q == Q_SAMPLE);
	// released line high in the acknowledge slot means nobody answered
	wire nack_now = sample & (cur_op == OP_TX) & ack_slot & sda_filt;
	wire rx_shift = sample & (cur_op == OP_RX) & ~ack_slot;
	wire frame_end = q_end & (cur_op == OP_STOP);
	wire frame_ok = frame_end & ~nack_cur;
	wire last_word = (load_idx == LOAD_AW'(LOAD_WORDS - 1));
	wire load_next = frame_ok & autoload_act & ~last_word;
	wire load_finish = frame_end & autoload_act & (nack_cur | last_word);
	wire sw_end = frame_end & ~autoload_act;
	wire idle = ce & ~running;
	// autoload is owed once per reset; a disable written on that very edge still holds it off
	wire load_start = idle & load_pending & ~load_dis & ~(wr_csr & pwdata[B_LDIS]);
	wire load_skip = idle & load_pending & (load_dis | (wr_csr & pwdata[B_LDIS]));
	// only a zero to one change of initiate starts a cycle
	wire start_req = ce & wr_csr & pwdata[B_INIT] & ~init_bit & ~running & ~load_pending & ~autoload_act;
	wire mem_we = ce & frame_ok & autoload_act;
	wire [IRQ_W-1:0] irq_ev = {load_finish, nack_now, sw_end};

	// read back of the control word, busy shows the loader
	wire [31:0] csr_rdata = {data_field, word_addr, autoload_act, fast_load, load_dis, clk_sel,
		load_done, err_flag, cmd_bit, init_bit};
	wire [31:0] reg_rdata = hit_csr ? csr_rdata :
		hit_stat ? {29'h0, irq_stat} :
		hit_mask ? {29'h0, irq_mask} : 32'h0;

	assign pready = ce & (~hit_mem | mem_wait);
	assign pslverr = access & (~hit_any | (pwrite & hit_mem));
	assign irq = |(irq_stat & irq_mask);
	assign rom_sda_out = 1'b0;

	seac_clkdiv u_div (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.run(running),
		.sel(clk_sel),
		.fast(autoload_act & fast_load),
		.tick(tick)
	);

	seac_shadow_mem u_mem (
		.pclk(pclk),
		.ce(ce),
		.we(mem_we),
		.waddr(load_idx),
		.wdata(rx_word),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// three stage input sync, a change counts when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
			sda_filt <= 1'b1;
		end else if (ce) begin
			sda_s1 <= rom_sda_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
			if (sda_s2 == sda_s3) begin
				sda_filt <= sda_s3;
			end
		end
	end

	// pins registered, both lines idle high between frames
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_scl <= 1'b1;
			rom_sda_oe_n <= 1'b1;
		end else if (ce) begin
			rom_scl <= running ? scl_want : 1'b1;
			rom_sda_oe_n <= running ? sda_want : 1'b1;
		end
	end

	// engine state and frame position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			step <= STEP_FIRST;
			bitn <= '0;
			q <= '0;
		end else if (ce) begin
			case (state)
				S_IDLE: begin
					step <= STEP_FIRST;
					bitn <= '0;
					q <= '0;
					// software or loader kicks off a frame
					if (start_req || load_start) begin
						state <= S_RUN;
					end
				end
				S_RUN: begin
					if (tick) begin
						q <= q + 2'd1;
					end
					if (frame_end) begin
						// next autoload word chains without a gap
						state <= load_next ? S_RUN : S_IDLE;
						step <= STEP_FIRST;
					end else if (q_end && cur_op == OP_START) begin
						step <= step + 3'd1;
					end else if (q_end && ack_slot) begin
						// a lost acknowledge cuts straight to stop
						step <= nack_cur ? stop_step : step + 3'd1;
						bitn <= '0;
					end else if (q_end) begin
						bitn <= bitn + 4'd1;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// frame operands, latched so software may rewrite fields mid frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_read <= 1'b1;
			cur_addr <= '0;
			cur_wdata <= '0;
			rx_word <= '0;
			nack_cur <= 1'b0;
		end else if (ce) begin
			if (load_start) begin
				cur_read <= 1'b1;
				cur_addr <= '0;
				nack_cur <= 1'b0;
			end else if (start_req) begin
				// operands come from the same write that sets initiate
				cur_read <= ~pwdata[B_CMD];
				cur_addr <= pwdata[F_ADDR_LSB +: ADDR_W];
				cur_wdata <= pwdata[F_DATA_LSB +: DATA_W];
				nack_cur <= 1'b0;
			end else if (load_next) begin
				// words are fetched in rising address order
				cur_addr <= cur_addr + 7'd1;
				nack_cur <= 1'b0;
			end else if (nack_now) begin
				nack_cur <= 1'b1;
			end
			if (rx_shift) begin
				rx_word <= {rx_word[DATA_W-2:0], sda_filt};
			end
		end
	end

	// autoload bookkeeping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_pending <= 1'b1;
			autoload_act <= 1'b0;
			load_idx <= '0;
			load_done <= 1'b0;
		end else if (ce) begin
			if (load_start || load_skip) begin
				load_pending <= 1'b0;
			end
			if (load_start) begin
				autoload_act <= 1'b1;
				load_idx <= '0;
				load_done <= 1'b0;
			end else if (load_next) begin
				load_idx <= load_idx + LOAD_AW'(1);
			end else if (load_finish) begin
				autoload_act <= 1'b0;
				load_done <= ~nack_cur;
			end
		end
	end

	// control word: software fields and hardware status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_bit <= 1'b0;
			cmd_bit <= 1'b0;
			err_flag <= 1'b0;
			clk_sel <= 2'b00;
			load_dis <= 1'b0;
			fast_load <= FAST_RST;
			word_addr <= '0;
			data_field <= '0;
		end else if (ce) begin
			if (wr_csr) begin
				cmd_bit <= pwdata[B_CMD];
				clk_sel <= pwdata[F_CLK_LSB +: 2];
				load_dis <= pwdata[B_LDIS];
				fast_load <= pwdata[B_FAST];
				word_addr <= pwdata[F_ADDR_LSB +: ADDR_W];
				data_field <= pwdata[F_DATA_LSB +: DATA_W];
			end
			if (start_req) begin
				init_bit <= 1'b1;
			end else if (sw_end) begin
				init_bit <= 1'b0;
			end
			// error covers the latest cycle or the whole autoload
			if (nack_now) begin
				err_flag <= 1'b1;
			end else if (start_req || load_start) begin
				err_flag <= 1'b0;
			end
			// read result beats a software write of the same cycle
			if (sw_end && cur_read && !nack_cur) begin
				data_field <= rx_word;
			end
		end
	end

	// interrupt status and mask, a new event beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq_mask <= '0;
		end else if (ce) begin
			irq_stat <= (irq_stat & ~((wr_en & hit_stat) ? pwdata[IRQ_W-1:0] : 3'h0)) | irq_ev;
			if (wr_en && hit_mask) begin
				irq_mask <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// read data taken in setup, shadow words one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			mem_wait <= 1'b0;
		end else if (ce) begin
			mem_wait <= psel & penable & hit_mem & ~mem_wait;
			if (psel && !penable) begin
				prdata <= reg_rdata;
			end else if (psel && penable && hit_mem && !mem_wait) begin
				prdata <= {16'h0, mem_rdata};
			end
		end
	end

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		start_req |=> running && init_bit;
	endproperty
	a_start: assert property (p_start) else $error("initiate did not start a cycle");

	property p_init_clear;
		@(posedge pclk) disable iff (!presetn)
		sw_end |=> !init_bit && !running;
	endproperty
	a_init_clear: assert property (p_init_clear) else $error("initiate not cleared at end");

	property p_err;
		@(posedge pclk) disable iff (!presetn)
		nack_now |=> err_flag ##1 (err_flag || !running);
	endproperty
	a_err: assert property (p_err) else $error("missing acknowledge not flagged");

	property p_done;
		@(posedge pclk) disable iff (!presetn)
		load_finish |=> (load_done == !$past(nack_cur)) && !autoload_act;
	endproperty
	a_done: assert property (p_done) else $error("completion flag wrong");

	property p_skip;
		@(posedge pclk) disable iff (!presetn)
		load_skip |=> !autoload_act && !load_pending;
	endproperty
	a_skip: assert property (p_skip) else $error("autoload ran while disabled");

	property p_busy;
		@(posedge pclk) disable iff (!presetn)
		load_start |=> csr_rdata[B_BUSY] && running;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not shown during autoload");

	property p_addr;
		@(posedge pclk) disable iff (!presetn)
		start_req |=> cur_addr == $past(pwdata[F_ADDR_LSB +: ADDR_W]) && cur_read == !$past(pwdata[B_CMD]);
	endproperty
	a_addr: assert property (p_addr) else $error("cycle address or direction wrong");

	property p_rd_data;
		@(posedge pclk) disable iff (!presetn)
		(sw_end && cur_read && !nack_cur) |=> data_field == $past(rx_word);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read word not stored");

	property p_load_order;
		@(posedge pclk) disable iff (!presetn)
		load_next |=> cur_addr == $past(cur_addr) + 7'd1 && running;
	endproperty
	a_load_order: assert property (p_load_order) else $error("autoload skipped a word");
endmodule // seac_ctrl

/* File: verification/seac_rom_model.sv */
`timescale 1ns/1ns
// behavioural serial rom on the far side of the two-wire link
module seac_rom_model #(
	parameter logic [6:0] DEV_SEL = 7'h50 // bus select code, arbitrary
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack_all,
	output logic pull_low
);
	logic [15:0] mem [0:127]; // word store, survives device resets
	logic [7:0] shreg; // incoming byte
	logic [7:0] whi; // high byte of a pending write
	logic [3:0] nbit; // slot within the byte, nine with acknowledge
	logic [2:0] nbyte; // bytes since the last start
	logic [6:0] wptr; // word pointer
	logic [15:0] tx; // outgoing word, msb first
	logic sending; // we own the data slots
	logic ok; // acknowledge decision

	// known contents so that reads can be predicted
	initial begin
		pull_low = 1'b0;
		nbit = 4'h0;
		nbyte = 3'h0;
		sending = 1'b0;
		wptr = 7'h00;
		for (int i = 0; i < 128; i++) begin
			mem[i] = 16'hC300 | 16'(i);
		end
	end

	// start or repeated start: data falls while the clock is high
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			nbit = 4'h0;
			nbyte = 3'h0;
			sending = 1'b0;
			pull_low = 1'b0;
		end
	end

	// stop: let go of the line
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			sending = 1'b0;
			pull_low = 1'b0;
		end
	end

	// shift in on the rising clock
	always @(posedge scl) begin
		if (nbit < 4'h8) begin
			shreg = {shreg[6:0], sda};
		end
		nbit = nbit + 4'h1;
	end

	// change the line only while the clock is low, never disturbing a start or stop
	always @(negedge scl) begin
		if (nbit == 4'h8) begin
			if (sending) begin
				tx = tx << 1;
				pull_low = 1'b0;
			end else begin
				ok = !nack_all;
				case (nbyte)
				3'h0: begin
					ok = ok && (shreg[7:1] == DEV_SEL);
					sending = ok && shreg[0];
					tx = mem[wptr];
				end
				3'h1: wptr = shreg[6:0];
				3'h2: whi = shreg;
				default: if (ok) mem[wptr] = {whi, shreg};
				endcase
				pull_low = ok;
			end
			nbyte = nbyte + 3'h1;
		end else if (nbit == 4'h9) begin
			// after the low byte the master refuses, so we stay released
			nbit = 4'h0;
			pull_low = sending && (nbyte < 3'h3) && !tx[15];
		end else if (sending) begin
			tx = tx << 1;
			pull_low = !tx[15];
		end
	end
endmodule // seac_rom_model

/* File: verification/seac_ctrl_test.sv */
`timescale 1ns/1ns
// self-checking bench for the serial rom controller
module seac_ctrl_test;
	import seac_pkg::*;
	localparam int LIMIT = 95000; // cycle ceiling, slowest path is the refused read at divider code one
	logic pclk; // core clock
	logic presetn; // async reset
	logic psel, penable, pwrite; // apb controls
	logic [11:0] paddr; // byte address
	logic [31:0] pwdata, prdata; // write and read data
	logic pready, pslverr, irq; // device answers
	logic rom_scl, rom_sda_oe_n, rom_sda_out, pull_low, nack_all; // link side
	wire sda; // resolved data line with pull-up
	logic [31:0] v; // last read value
	logic e; // last error response
	int n_errors = 0;
	int checks = 0;
	int cyc = 0; // elapsed cycles
	int per; // measured serial clock period

	// device shows its drive value while enabled, the rom pulls low, otherwise the pull-up wins
	assign sda = (rom_sda_oe_n ? 1'b1 : rom_sda_out) & ~pull_low;

	seac_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.rom_scl(rom_scl), .rom_sda_in(sda), .rom_sda_out(rom_sda_out), .rom_sda_oe_n(rom_sda_oe_n));
	seac_rom_model rom (.scl(rom_scl), .sda(sda), .nack_all(nack_all), .pull_low(pull_low));

	// free running clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("MISMATCH time %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_errors = n_errors + 1;
			test_done();
		end
	end

	// one apb transfer, entered just after a rising edge; idles one cycle after
	// answer looked at mid cycle, where it is settled for the coming rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(negedge pclk);
		while (pready !== 1'b1) begin
			@(negedge pclk);
		end
		v = prdata;
		e = pslverr;
		// the completing edge, request still standing
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// poll the control word until a bit drops; the cycle ceiling bounds it
	task automatic wait_low(input int b);
		apb(1'b0, ADDR_CSR, 32'h0);
		while (v[b] !== 1'b0) begin
			apb(1'b0, ADDR_CSR, 32'h0);
		end
	endtask

	// rising to rising distance of the serial clock, in core cycles
	task automatic scl_period();
		realtime t0;
		@(posedge rom_scl);
		t0 = $realtime;
		@(posedge rom_scl);
		per = int'(($realtime - t0) / 20.0);
		@(posedge pclk);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		nack_all = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// autoload against a silent rom, fast rate at divider code zero
		scl_period();
		check(32'(per), 32'h200);
		apb(1'b0, ADDR_CSR, 32'h0);
		check(v, 32'h180);
		wait_low(B_BUSY);
		check(v, 32'h84);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check(v, 32'h6);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h7);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h6);
		check({31'h0, irq}, 32'h0);
		$display("test refused autoload done");
		// software write, then a read of another word
		nack_all <= 1'b0;
		apb(1'b1, ADDR_CSR, 32'hA5C35433);
		scl_period();
		check(32'(per), 32'h80);
		wait_low(B_INIT);
		check(v, 32'hA5C35432);
		check({16'h0, rom.mem[42]}, 32'hA5C3);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check(v, 32'h1);
		apb(1'b1, ADDR_CSR, 32'h00002A31);
		wait_low(B_INIT);
		check(v, 32'hC3152A30);
		$display("test software cycles done");
		// refused software read at divider code two keeps the data field
		nack_all <= 1'b1;
		apb(1'b1, ADDR_CSR, 32'h00000021);
		scl_period();
		check(32'(per), 32'h400);
		wait_low(B_INIT);
		check(v, 32'h24);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check(v & 32'h2, 32'h2);
		check({31'h0, irq}, 32'h1);
		$display("test missing acknowledge done");
		// second reset, full autoload with the quickest divider
		nack_all <= 1'b0;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b1, ADDR_CSR, 32'hB0);
		wait_low(B_BUSY);
		check(v, 32'hB8);
		for (int i = 0; i < LOAD_WORDS; i++) begin
			apb(1'b0, ADDR_SHADOW + 12'(4 * i), 32'h0);
			check(v, 32'hC300 | 32'(i));
		end
		// unmapped read and read-only window write
		apb(1'b0, 12'h0F0, 32'h0);
		check({v[30:0], e}, 32'h1);
		apb(1'b1, ADDR_SHADOW, 32'hFFFF);
		check({31'h0, e}, 32'h1);
		$display("test full autoload done");
		// third reset, disable bit written on the first edge after release
		presetn <= 1'b0;
		repeat (7) @(posedge pclk);
		fork
			apb(1'b1, ADDR_CSR, 32'hC0);
			begin
				@(posedge pclk);
				presetn <= 1'b1;
			end
		join
		apb(1'b0, ADDR_CSR, 32'h0);
		check(v, 32'hC0);
		// refused software read at divider code one, fast bit has no effect outside autoload
		nack_all <= 1'b1;
		apb(1'b1, ADDR_CSR, 32'hD1);
		scl_period();
		check(32'(per), 32'h800);
		wait_low(B_INIT);
		check(v, 32'hD4);
		$display("test skipped autoload done");
		test_done();
	end
endmodule // seac_ctrl_test
